/* rtl/deadband_delay.sv */
// Purpose: holds back the inactive-to-active edge of one output
// Assumes: delay is given in instruction cycles of four clocks
// Notes:   falling edges pass after one register stage only
`default_nettype none

module deadband_delay
	import pwm_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       level_in,
	input  wire logic [6:0] delay,
	output logic            level_out
);

	logic [DB_CNT_W-1:0] cnt;

	// a delay longer than the pulse keeps the output inactive all cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !level_in) begin
			cnt       <= '0;
			level_out <= 1'b0;
		end else if (cnt >= {delay, 2'b00}) begin
			level_out <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

endmodule

`default_nettype wire

/* rtl/enhanced_bridge_pwm_unit.sv */
// Purpose: enhanced capture/compare/pwm unit with bridge outputs
// Assumes: Avalon-MM slave, ref_clk is the oscillator clock
// Notes:   pins a..d come with output enables; enable low = port function
//
// Local design decisions: the address map and the Avalon-MM register port.
`default_nettype none

module enhanced_bridge_pwm_unit
	import pwm_pkg::*;
#(
	parameter int LAG = INSTR_CLKS
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	input  wire logic              capture_in,
	input  wire logic              adc_enabled,
	output logic                   adc_start,
	output logic                   special_event,
	output logic                   pwm_out_a,
	output logic                   pwm_out_b,
	output logic                   pwm_out_c,
	output logic                   pwm_out_d,
	output logic                   pwm_oe_a,
	output logic                   pwm_oe_b,
	output logic                   pwm_oe_c,
	output logic                   pwm_oe_d
);

	// ----------------------------------------------------------------
	// registers and wires
	// ----------------------------------------------------------------
	control_t    unit_control_reg;
	timer_ctrl_t timer_ctrl;
	logic [7:0]  duty_low_reg;
	logic [7:0]  duty_buffer_reg;
	logic [6:0]  deadband_count;
	logic [7:0]  period_reg;
	logic [15:0] timer_one_count;
	logic [15:0] timer_three_count;
	logic [1:0]  status;
	logic [31:0] next_readdata;
	logic        wr_ok;
	logic [3:0]  mode;
	logic [3:0]  mode_prev;
	logic        pwm_mode;
	logic        cmp_mode;
	logic        cap_mode;
	logic [1:0]  qcnt;
	logic        tick;
	logic [15:0] sel_timer;
	logic        cmp_match;
	logic        trig;
	logic        cmp_pin;
	logic        cap_s1;
	logic        cap_s2;
	logic        cap_s3;
	logic        cap_edge;
	logic [3:0]  cap_div;
	logic [3:0]  cap_need;
	logic        capture;
	logic [7:0]  pt_count;
	logic [1:0]  pt_sub;
	logic        period_start;
	logic        post_tick;
	logic        pwm_live;
	out_cfg_t    sh_cfg;
	logic [1:0]  sh_pol;
	logic [1:0]  lsb_latch;
	logic [6:0]  sh_db;
	logic        pwm_raw;
	logic        duty_hit;
	logic [LAG-1:0] pwm_lag;
	logic        p;
	logic [3:0]  act;
	logic [3:0]  db_out;
	logic [3:0]  inv;
	logic [3:0]  oe_cfg;

	assign mode     = unit_control_reg.unit_mode_field;
	assign pwm_mode = (mode[3:2] == MODE_PWM_TOP);
	assign cmp_mode = (mode[3:2] == 2'b10) || (mode == MODE_TOGGLE);
	assign cap_mode = (mode[3:2] == MODE_CAP_TOP);
	assign wr_ok    = write && !waitrequest;
	assign tick     = (qcnt == 2'b11);

	// ----------------------------------------------------------------
	// bus slave: one wait cycle, then the answer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	always_comb begin
		case (address)
			OFS_CONTROL:      next_readdata = {24'h0, unit_control_reg};
			OFS_DUTY_LOW:     next_readdata = {24'h0, duty_low_reg};
			OFS_DUTY_BUFFER:  next_readdata = {24'h0, duty_buffer_reg};
			OFS_DEADBAND:     next_readdata = {25'h0, deadband_count};
			OFS_PERIOD:       next_readdata = {24'h0, period_reg};
			OFS_TIMER_CTRL:   next_readdata = {22'h0, timer_ctrl};
			OFS_PERIOD_TIMER: next_readdata = {24'h0, pt_count};
			OFS_TIMER_ONE:    next_readdata = {16'h0, timer_one_count};
			OFS_TIMER_THREE:  next_readdata = {16'h0, timer_three_count};
			OFS_STATUS:       next_readdata = {30'h0, status};
			default:          next_readdata = 32'h0;
		endcase
	end

	// read data is caught one edge early so it stands while wait is low
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			readdata <= 32'h0;
		end else if (read && waitrequest) begin
			readdata <= next_readdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			unit_control_reg <= control_t'(CONTROL_RST);
			deadband_count   <= DEADBAND_RST;
			period_reg       <= PERIOD_RST;
			timer_ctrl       <= timer_ctrl_t'(TIMER_CTRL_RST);
		end else if (wr_ok) begin
			case (address)
				OFS_CONTROL:    unit_control_reg <= control_t'(writedata[7:0]);
				OFS_DEADBAND:   deadband_count <= writedata[6:0];
				OFS_PERIOD:     period_reg <= writedata[7:0];
				OFS_TIMER_CTRL: timer_ctrl <= timer_ctrl_t'(writedata[9:0]);
				default: begin
				end
			endcase
		end
	end

	// duty pair doubles as the 16-bit compare and capture register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			duty_low_reg    <= DUTY_RST;
			duty_buffer_reg <= DUTY_RST;
		end else if (capture) begin
			{duty_buffer_reg, duty_low_reg} <= sel_timer;
		end else begin
			if (wr_ok && address == OFS_DUTY_LOW)
				duty_low_reg <= writedata[7:0];
			if (pwm_mode && period_start)
				duty_buffer_reg <= duty_low_reg;
			else if (wr_ok && address == OFS_DUTY_BUFFER && !pwm_mode)
				duty_buffer_reg <= writedata[7:0];
		end
	end

	// sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			status <= 2'b00;
		end else begin
			status <= (status & ~((wr_ok && address == OFS_STATUS) ?
				writedata[1:0] : 2'b00)) | {post_tick, cmp_match | capture};
		end
	end

	// ----------------------------------------------------------------
	// instruction tick and 16-bit timers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			qcnt <= 2'b00;
		end else begin
			qcnt <= qcnt + 1'b1;
		end
	end

	assign sel_timer = timer_ctrl.cmp_sel_three ? timer_three_count
		: timer_one_count;
	assign cmp_match = cmp_mode && tick
		&& (sel_timer == {duty_buffer_reg, duty_low_reg});
	assign trig = cmp_match && (mode == MODE_CMP_TRIG);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			timer_one_count <= TIMER16_RST;
		end else if (wr_ok && address == OFS_TIMER_ONE) begin
			timer_one_count <= writedata[15:0];
		end else if (trig && !timer_ctrl.cmp_sel_three) begin
			timer_one_count <= TIMER16_RST;
		end else if (timer_ctrl.one_on && tick) begin
			timer_one_count <= timer_one_count + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			timer_three_count <= TIMER16_RST;
		end else if (wr_ok && address == OFS_TIMER_THREE) begin
			timer_three_count <= writedata[15:0];
		end else if (trig && timer_ctrl.cmp_sel_three) begin
			timer_three_count <= TIMER16_RST;
		end else if (timer_ctrl.three_on && tick) begin
			timer_three_count <= timer_three_count + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			special_event <= 1'b0;
			adc_start     <= 1'b0;
		end else begin
			special_event <= trig;
			adc_start     <= trig && adc_enabled;
		end
	end

	// ----------------------------------------------------------------
	// compare pin and capture
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_prev <= MODE_OFF;
			cmp_pin   <= 1'b0;
		end else begin
			mode_prev <= mode;
			if (mode != mode_prev)
				cmp_pin <= (mode == MODE_CMP_CLR);
			else if (cmp_match && mode == MODE_CMP_SET)
				cmp_pin <= 1'b1;
			else if (cmp_match && mode == MODE_CMP_CLR)
				cmp_pin <= 1'b0;
			else if (cmp_match && mode == MODE_TOGGLE)
				cmp_pin <= !cmp_pin;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cap_s1 <= 1'b0;
			cap_s2 <= 1'b0;
			cap_s3 <= 1'b0;
		end else begin
			cap_s1 <= capture_in;
			cap_s2 <= cap_s1;
			cap_s3 <= cap_s2;
		end
	end

	assign cap_edge = (mode == MODE_CAP_FALL) ? (cap_s3 && !cap_s2)
		: (!cap_s3 && cap_s2);
	assign cap_need = (mode == MODE_CAP_4TH) ? 4'h3
		: (mode == MODE_CAP_16TH) ? 4'hf : 4'h0;
	assign capture = cap_mode && cap_edge && (cap_div == cap_need);

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !cap_mode || mode != mode_prev) begin
			cap_div <= 4'h0;
		end else if (cap_mode && cap_edge) begin
			cap_div <= capture ? 4'h0 : cap_div + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// pwm time base and duty
	// ----------------------------------------------------------------
	period_timer_unit #(
		.TW(8)
	) u_period_timer (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.run         (timer_ctrl.period_on),
		.prescale    (timer_ctrl.prescale),
		.period      (period_reg),
		.postscale   (timer_ctrl.postscale),
		.count       (pt_count),
		.sub         (pt_sub),
		.period_start(period_start),
		.post_tick   (post_tick)
	);

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !pwm_mode) begin
			pwm_live  <= 1'b0;
			sh_cfg    <= CFG_SINGLE;
			sh_pol    <= 2'b00;
			lsb_latch <= 2'b00;
		end else if (period_start) begin
			pwm_live  <= 1'b1;
			sh_cfg    <= out_cfg_t'(unit_control_reg.output_config_field);
			sh_pol    <= mode[1:0];
			lsb_latch <= unit_control_reg.duty_lsbs;
		end
	end

	// a duty beyond the period never matches, so the pulse stays set
	assign duty_hit = ({pt_count, pt_sub} == {duty_buffer_reg, lsb_latch});

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !pwm_mode) begin
			pwm_raw <= 1'b0;
		end else if (period_start) begin
			pwm_raw <= ({duty_low_reg, unit_control_reg.duty_lsbs} != 10'h0);
		end else if (duty_hit) begin
			pwm_raw <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n || !pwm_mode) begin
			sh_db <= DEADBAND_RST;
		end else if (period_start || (pwm_raw && duty_hit)) begin
			sh_db <= deadband_count;
		end
	end

	// one instruction cycle of lag behind the standard waveform
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !pwm_mode) begin
			pwm_lag <= '0;
		end else begin
			pwm_lag <= {pwm_lag[LAG-2:0], pwm_raw};
		end
	end

	assign p = pwm_lag[LAG-1];

	// ----------------------------------------------------------------
	// output steering, dead band and polarity
	// ----------------------------------------------------------------
	always_comb begin
		case (sh_cfg)
			CFG_SINGLE: begin
				act    = {3'b000, p};
				oe_cfg = 4'b0001;
			end
			CFG_HALF: begin
				act    = {2'b00, !p, p};
				oe_cfg = 4'b0011;
			end
			CFG_FWD: begin
				act    = {p, 2'b00, 1'b1};
				oe_cfg = 4'b1111;
			end
			default: begin
				act    = {1'b0, 1'b1, p, 1'b0};
				oe_cfg = 4'b1111;
			end
		endcase
	end

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_db
			deadband_delay u_db (
				.ref_clk  (ref_clk),
				.rst_n    (rst_n),
				.level_in (act[ch] && pwm_live),
				.delay    ((sh_cfg == CFG_HALF && ch < 2) ? sh_db : 7'h00),
				.level_out(db_out[ch])
			);
		end
	endgenerate

	assign inv = {sh_pol[0], sh_pol[1], sh_pol[0], sh_pol[1]};

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			{pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} <= 4'h0;
			{pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a}     <= 4'h0;
		end else if (pwm_mode && pwm_live) begin
			{pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} <= db_out ^ inv;
			{pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a}     <= oe_cfg;
		end else if (mode == MODE_CMP_SET || mode == MODE_CMP_CLR
				|| mode == MODE_TOGGLE) begin
			{pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} <= {3'b000, cmp_pin};
			{pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a}     <= 4'h1;
		end else begin
			{pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} <= 4'h0;
			{pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a}     <= 4'h0;
		end
	end

endmodule

`default_nettype wire

/* rtl/period_timer_unit.sv */
// Purpose: 8-bit period timer with prescaler, quarter count and postscaler
// Assumes: prescale select 00 = 1, 01 = 4, 1x = 16 timer steps
// Notes:   sub gives the two fine bits that extend the count to 10 bits
`default_nettype none

module period_timer_unit
	import pwm_pkg::*;
#(
	parameter int TW = 8
) (
	input  wire logic          ref_clk,
	input  wire logic          rst_n,
	input  wire logic          run,
	input  wire logic [1:0]    prescale,
	input  wire logic [TW-1:0] period,
	input  wire logic [3:0]    postscale,
	output logic      [TW-1:0] count,
	output logic      [1:0]    sub,
	output logic               period_start,
	output logic               post_tick
);

	logic [PRESC_W-1:0] presc;
	logic [PRESC_W-1:0] presc_max;
	logic [3:0]         post_cnt;

	// ----------------------------------------------------------------
	// prescale decode
	// ----------------------------------------------------------------
	always_comb begin
		case (prescale)
			2'b00: begin
				presc_max = 6'h03;
				sub       = presc[1:0];
			end
			2'b01: begin
				presc_max = 6'h0f;
				sub       = presc[3:2];
			end
			default: begin
				presc_max = 6'h3f;
				sub       = presc[5:4];
			end
		endcase
	end

	// ----------------------------------------------------------------
	// count and period match
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !run) begin
			presc        <= '0;
			count        <= '0;
			period_start <= 1'b0;
		end else begin
			period_start <= 1'b0;
			if (presc == presc_max) begin
				presc <= '0;
				if (count == period) begin
					count        <= '0;
					period_start <= 1'b1;
				end else begin
					count <= count + 1'b1;
				end
			end else begin
				presc <= presc + 1'b1;
			end
		end
	end

	// postscaler only paces the update flag, never the period
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !run) begin
			post_cnt  <= 4'h0;
			post_tick <= 1'b0;
		end else begin
			post_tick <= 1'b0;
			if (period_start) begin
				if (post_cnt == postscale) begin
					post_cnt  <= 4'h0;
					post_tick <= 1'b1;
				end else begin
					post_cnt <= post_cnt + 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

/* rtl/pwm_pkg.sv */
// Purpose: shared constants and types of the enhanced bridge pwm unit
// Assumes: ref_clk is the oscillator clock, four periods per instruction
// Notes:   register offsets are byte addresses, one 32-bit word each
`default_nettype none

package pwm_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int INSTR_CLKS = 4;
	localparam int PRESC_W    = 6;
	localparam int DB_CNT_W   = 9;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_CONTROL      = 6'h00;
	localparam logic [5:0] OFS_DUTY_LOW     = 6'h04;
	localparam logic [5:0] OFS_DUTY_BUFFER  = 6'h08;
	localparam logic [5:0] OFS_DEADBAND     = 6'h0c;
	localparam logic [5:0] OFS_PERIOD       = 6'h10;
	localparam logic [5:0] OFS_TIMER_CTRL   = 6'h14;
	localparam logic [5:0] OFS_PERIOD_TIMER = 6'h18;
	localparam logic [5:0] OFS_TIMER_ONE    = 6'h1c;
	localparam logic [5:0] OFS_TIMER_THREE  = 6'h20;
	localparam logic [5:0] OFS_STATUS       = 6'h24;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  CONTROL_RST    = 8'h00;
	localparam logic [7:0]  DUTY_RST       = 8'h00;
	localparam logic [6:0]  DEADBAND_RST   = 7'h00;
	localparam logic [7:0]  PERIOD_RST     = 8'hff;
	localparam logic [9:0]  TIMER_CTRL_RST = 10'h000;
	localparam logic [15:0] TIMER16_RST    = 16'h0000;

	// ----------------------------------------------------------------
	// modes and output arrangements
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_OFF      = 4'h0;
	localparam logic [3:0] MODE_TOGGLE   = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_4TH  = 4'h6;
	localparam logic [3:0] MODE_CAP_16TH = 4'h7;
	localparam logic [3:0] MODE_CMP_SET  = 4'h8;
	localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
	localparam logic [3:0] MODE_CMP_SW   = 4'ha;
	localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
	localparam logic [1:0] MODE_PWM_TOP  = 2'b11;
	localparam logic [1:0] MODE_CAP_TOP  = 2'b01;

	typedef enum logic [1:0] {
		CFG_SINGLE = 2'b00,
		CFG_FWD    = 2'b01,
		CFG_HALF   = 2'b10,
		CFG_REV    = 2'b11
	} out_cfg_t;

	typedef struct packed {
		logic [1:0] output_config_field;
		logic [1:0] duty_lsbs;
		logic [3:0] unit_mode_field;
	} control_t;

	typedef struct packed {
		logic       three_on;
		logic       one_on;
		logic       cmp_sel_three;
		logic [3:0] postscale;
		logic       period_on;
		logic [1:0] prescale;
	} timer_ctrl_t;

endpackage

`default_nettype wire

/* verification/bridge_driver_model.sv */
// Purpose: power switch driver stage seen by the four pins
// Assumes: pins a/b and c/d form the two bridge legs
// Notes:   counts high cycles per pin and leg overlaps since clr
`default_nettype none

module bridge_driver_model (
	input  wire logic        ref_clk,
	input  wire logic        clr,
	input  wire logic [3:0]  drv,
	input  wire logic [3:0]  en,
	output logic [3:0][15:0] hi,
	output logic [15:0]      shoot
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] pin;
	// released pins sink to the driver pull-down, not the last level
	assign pin = drv & en;
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < 4; i++)
			hi[i] <= clr ? 16'h0 : hi[i] + 16'(pin[i]);
		shoot <= clr ? 16'h0 : shoot + 16'(pin[0] & pin[1] | pin[2] & pin[3]);
	end
endmodule

`default_nettype wire

/* verification/enhanced_bridge_pwm_unit_tb.sv */
// Purpose: register-driven tests of the enhanced bridge pwm unit
// Assumes: period register 9, so one pwm cycle is 40 clocks at prescale 1
// Notes:   counts are taken over one whole period after settling
`default_nettype none

module enhanced_bridge_pwm_unit_tb
	import pwm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic              ref_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic [31:0]       writedata = '0;
	logic [31:0]       readdata;
	logic [31:0]       d;
	logic              waitrequest;
	logic              adc_enabled = 1'b0;
	logic              adc_start;
	logic              special_event;
	logic              clr = 1'b0;
	logic [3:0]        out;
	logic [3:0]        oe;
	logic [3:0][15:0]  hi;
	logic [15:0]       shoot;
	int                err_total = 0;
	int                n_tests = 0;
	int                k;

	always #10 ref_clk = ~ref_clk;

	enhanced_bridge_pwm_unit dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .capture_in(1'b1),
		.adc_enabled(adc_enabled), .adc_start(adc_start),
		.special_event(special_event), .pwm_out_a(out[0]),
		.pwm_out_b(out[1]), .pwm_out_c(out[2]), .pwm_out_d(out[3]),
		.pwm_oe_a(oe[0]), .pwm_oe_b(oe[1]), .pwm_oe_c(oe[2]),
		.pwm_oe_d(oe[3]));
	bridge_driver_model drv (.ref_clk(ref_clk), .clr(clr), .drv(out),
		.en(oe), .hi(hi), .shoot(shoot));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic results();
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic fail(input string m);
		err_total++;
		$display("Error t=%0t %s", $time, m);
	endtask
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
			fail($sformatf("value %h expected %h", g, e));
	endtask
	task automatic chk_cnt(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e)
			fail($sformatf("count %0d expected %0d", g, e));
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic rw, input logic [5:0] a,
		input logic [31:0] wd);
		address <= a;
		writedata <= wd;
		read <= !rw;
		write <= rw;
		for (k = 0; k < 20; k++) begin
			@(posedge ref_clk);
			if (waitrequest === 1'b0)
				break;
		end
		d = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (k == 20) begin
			fail("bus hang");
			results();
		end
		@(posedge ref_clk);
	endtask
	task automatic pw(input logic [7:0] ctl, dl, input int n,
		input logic [3:0] e_oe, input logic [15:0] ea, eb, ec, ed);
		bus(1'b1, OFS_DUTY_LOW, 32'(dl));
		bus(1'b1, OFS_CONTROL, 32'(ctl));
		repeat (3 * n) @(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
		chk_reg(32'(oe), 32'(e_oe));
		chk_cnt(hi[0], ea);
		chk_cnt(hi[1], eb);
		chk_cnt(hi[2], ec);
		chk_cnt(hi[3], ed);
		$display("pwm test done, control %h", ctl);
		@(posedge ref_clk);
	endtask
	// waits for one trigger; conversion start follows the enable
	task automatic sev(input logic en);
		adc_enabled <= en;
		for (k = 0; k < 200; k++) begin
			@(posedge ref_clk);
			if (special_event === 1'b1)
				break;
		end
		if (k == 200) begin
			fail("no special event");
			results();
		end
		chk_reg(32'(adc_start), 32'(en));
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk_reg(32'(oe), 32'h0);
		bus(1'b0, OFS_CONTROL, 32'h0);
		chk_reg(d, 32'h0);
		bus(1'b0, OFS_PERIOD, 32'h0);
		chk_reg(d, 32'hff);
		bus(1'b0, 6'h38, 32'h0);
		chk_reg(d, 32'h0);
		bus(1'b1, OFS_PERIOD, 32'h9);
		bus(1'b1, OFS_TIMER_CTRL, 32'h7c);
		pw(8'h0c, 8'h03, 40, 4'h1, 12, 0, 0, 0);
		bus(1'b0, OFS_DUTY_BUFFER, 32'h0);
		chk_reg(d, 32'h3);
		bus(1'b1, OFS_DUTY_BUFFER, 32'h55);
		bus(1'b0, OFS_DUTY_BUFFER, 32'h0);
		chk_reg(d, 32'h3);
		pw(8'h1c, 8'h03, 40, 4'h1, 13, 0, 0, 0);
		pw(8'h0c, 8'hff, 40, 4'h1, 40, 0, 0, 0);
		pw(8'h0c, 8'h00, 40, 4'h1, 0, 0, 0, 0);
		pw(8'h4c, 8'h03, 40, 4'hf, 40, 0, 0, 12);
		pw(8'hcc, 8'h03, 40, 4'hf, 0, 12, 40, 0);
		for (int m = 0; m < 4; m++)
			pw(8'h8c | 8'(m), 8'h03, 40, 4'h3,
				m[1] ? 16'd28 : 16'd12, m[0] ? 16'd12 : 16'd28, 0, 0);
		bus(1'b1, OFS_DEADBAND, 32'h2);
		pw(8'h8c, 8'h03, 40, 4'h3, 4, 20, 0, 0);
		chk_cnt(shoot, 16'h0);
		bus(1'b1, OFS_DEADBAND, 32'h4);
		pw(8'h8c, 8'h03, 40, 4'h3, 0, 12, 0, 0);
		bus(1'b1, OFS_TIMER_CTRL, 32'h7d);
		pw(8'h0c, 8'h03, 160, 4'h1, 48, 0, 0, 0);
		bus(1'b1, OFS_CONTROL, 32'h0);
		repeat (8) @(posedge ref_clk);
		chk_reg(32'(oe), 32'h0);
		// compare value is {duty buffer, duty low}; trigger period 6 ticks
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, OFS_TIMER_CTRL, i ? 32'h280 : 32'h100);
			bus(1'b1, OFS_CONTROL, 32'h0b);
			bus(1'b1, OFS_DUTY_BUFFER, 32'h0);
			bus(1'b1, OFS_DUTY_LOW, 32'h5);
			sev(1'b1);
			sev(1'b0);
			bus(1'b0, i ? OFS_TIMER_THREE : OFS_TIMER_ONE, 32'h0);
			chk_reg(32'(d <= 32'h5), 32'h1);
			$display("compare test done, timer %0d", i);
		end
		results();
	end
endmodule

`default_nettype wire

/* verification/pwm_unit_properties.sv */
// Purpose: port-level properties of the enhanced bridge pwm unit
// Assumes: checker sees only the top ports
// Notes:   polarity is unknown here, so pin levels are left to the bench
`default_nettype none

module pwm_unit_properties
	import pwm_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic              read,
	input wire logic              write,
	input wire logic [31:0]       readdata,
	input wire logic              waitrequest,
	input wire logic              adc_enabled,
	input wire logic              adc_start,
	input wire logic              special_event,
	input wire logic              pwm_oe_a,
	input wire logic              pwm_oe_b,
	input wire logic              pwm_oe_c,
	input wire logic              pwm_oe_d
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_rel;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> !(pwm_oe_a || pwm_oe_b || pwm_oe_c || pwm_oe_d)
			&& waitrequest && !special_event;
	endproperty
	a_rel: assert property (p_rel)
		else $error("pins driven after reset");
	property p_ack;
		@(posedge ref_clk) disable iff (!rst_n)
		!waitrequest |=> waitrequest;
	endproperty
	a_ack: assert property (p_ack)
		else $error("waitrequest low too long");
	property p_cause;
		@(posedge ref_clk) disable iff (!rst_n)
		!waitrequest |-> $past(read || write);
	endproperty
	a_cause: assert property (p_cause)
		else $error("answer without request");
	property p_hole;
		@(posedge ref_clk) disable iff (!rst_n)
		read && waitrequest && address == 6'h38
			|=> !waitrequest && readdata == 32'h0;
	endproperty
	a_hole: assert property (p_hole)
		else $error("unmapped read not zero");
	property p_adc;
		@(posedge ref_clk) disable iff (!rst_n)
		adc_start |-> special_event && $past(adc_enabled);
	endproperty
	a_adc: assert property (p_adc)
		else $error("conversion start without cause");
	property p_adc_go;
		@(posedge ref_clk) disable iff (!rst_n)
		special_event && $past(adc_enabled) |-> adc_start;
	endproperty
	a_adc_go: assert property (p_adc_go)
		else $error("conversion start missing");
	property p_pulse;
		@(posedge ref_clk) disable iff (!rst_n)
		special_event |=> !special_event [*3];
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("special event too close");
	property p_dual;
		@(posedge ref_clk) disable iff (!rst_n)
		pwm_oe_b |-> pwm_oe_a;
	endproperty
	a_dual: assert property (p_dual)
		else $error("pin b driven without pin a");
	property p_quad;
		@(posedge ref_clk) disable iff (!rst_n)
		pwm_oe_c || pwm_oe_d |-> pwm_oe_a && pwm_oe_b && pwm_oe_c && pwm_oe_d;
	endproperty
	a_quad: assert property (p_quad)
		else $error("partial quad drive");
endmodule

bind enhanced_bridge_pwm_unit pwm_unit_properties u_props (
	.ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
	.write(write), .readdata(readdata), .waitrequest(waitrequest),
	.adc_enabled(adc_enabled), .adc_start(adc_start),
	.special_event(special_event), .pwm_oe_a(pwm_oe_a),
	.pwm_oe_b(pwm_oe_b), .pwm_oe_c(pwm_oe_c), .pwm_oe_d(pwm_oe_d));

`default_nettype wire
